// file: design/tcc_pkg.sv
`default_nettype none
package tcc_pkg;

   // ----------------------------------------------------------------
   // widths and counts
   // ----------------------------------------------------------------
   localparam int TCC_TW     = 16;
   localparam int TCC_NALERT = 4;
   localparam int TCC_BCW    = 8;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [TCC_TW-1:0]  TCC_TEMP_RST  = 16'h0000;
   localparam logic [TCC_TW-1:0]  TCC_LIMIT_RST = 16'h0000;
   localparam logic [TCC_TW-1:0]  TCC_HYST_RST  = 16'h0000;
   localparam logic [TCC_BCW-1:0] TCC_BCNT_RST  = 8'h00;
   localparam logic [2:0]         TCC_BURST_RST = 3'h0;

   // ----------------------------------------------------------------
   // field positions of the status byte
   // ----------------------------------------------------------------
   localparam int TCC_ST_CONV  = 0;
   localparam int TCC_ST_BURST = 1;
   localparam int TCC_ST_ALERT = 4;

   // ----------------------------------------------------------------
   // resolution codes: low hot bits dropped per code (18/16/14/12 bit)
   // ----------------------------------------------------------------
   localparam logic [TCC_TW-1:0] TCC_HRES_MASK0 = 16'hffff;
   localparam logic [TCC_TW-1:0] TCC_HRES_MASK1 = 16'hffff;
   localparam logic [TCC_TW-1:0] TCC_HRES_MASK2 = 16'hfffe;
   localparam logic [TCC_TW-1:0] TCC_HRES_MASK3 = 16'hfffc;
   localparam logic [TCC_TW-1:0] TCC_CRES_MASK1 = 16'hfffc;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TCC_MODE_NORMAL   = 2'b00,
      TCC_MODE_SHUTDOWN = 2'b01,
      TCC_MODE_BURST    = 2'b10
   } tcc_mode_t;

   typedef struct packed {
      logic junction_hot;
      logic dir_falling;
      logic pin_en;
   } tcc_alert_cfg_t;

   typedef struct packed {
      logic signed [TCC_TW-1:0] hot;
      logic signed [TCC_TW-1:0] cold;
   } tcc_sample_t;

endpackage
`default_nettype wire

// file: design/tcc_conv_control.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - hot resolution code 0..3 = 18/16/14/12 bits
// R2 - mode 0 normal, 1 shutdown, 2 burst
// R3 - four alerts, each with own limit
// R4 - alert one output doubles as interrupt
// R5 - each alert holds its own hysteresis
// R6 - alert pins low when asserted
// R7 - junction bit: 0 cold, 1 hot
// R8 - direction bit: 0 rising, 1 falling
// R9 - pin enable 0 keeps pin inactive
// R10 - clear one chosen alert only
// R11 - limits readable back by host
// R12 - eight-bit status collecting all flags
// R13 - hot readout signed, sixteenth degree LSB
// R14 - cold readout signed, same scaling
// R15 - difference readout hot minus cold
// R16 - conversion flag set on finished conversion
// R17 - hot readout read clears conversion flag
// R18 - burst takes 2^n samples, then stops
// R19 - burst result filtered into hot readout
// R20 - burst flag set when burst finishes
// R21 - burst count write clears burst flag
// R22 - three-bit sensor type code accepted
// R23 - filter coefficient 0 off, 7 strongest
// R24 - cold resolution 0 fine, 1 quarter
// R25 - alert asserts on crossing, releases past hysteresis
// R26 - normal runs back to back, shutdown idle
module tcc_conv_control
   import tcc_pkg::*;
(
   input  wire logic                           clk_sys,
   input  wire logic                           sys_rst,
   input  wire logic                           fe_conv_tick,
   input  wire logic [TCC_TW-1:0]              fe_hot_raw,
   input  wire logic [TCC_TW-1:0]              fe_cold_raw,
   input  wire logic [1:0]                     operating_mode_select,
   input  wire logic [1:0]                     hot_resolution_select,
   input  wire logic                           cold_resolution_select,
   input  wire logic [2:0]                     sensor_type_select,
   input  wire logic [2:0]                     filter_strength_select,
   input  wire logic                           burst_sample_count_write,
   input  wire logic [2:0]                     burst_sample_count,
   input  wire logic                           hot_junction_read,
   input  wire logic                           alert_configure,
   input  wire logic                           alert_threshold_write,
   input  wire logic                           alert_hysteresis_write,
   input  wire logic                           alert_clear,
   input  wire logic [1:0]                     alert_sel,
   input  wire tcc_alert_cfg_t                 alert_cfg_in,
   input  wire logic [TCC_TW-1:0]              alert_value_in,
   output logic [TCC_TW-1:0]                   hot_junction_readout,
   output logic [TCC_TW-1:0]                   cold_junction_readout,
   output logic [TCC_TW-1:0]                   junction_difference_readout,
   output logic                                conversion_done_flag,
   output logic                                burst_done_flag,
   output logic [7:0]                          status_readout,
   output logic [TCC_NALERT-1:0][TCC_TW-1:0]   alert_threshold_readback,
   output logic [TCC_NALERT-1:0]               alert_out_n,
   output logic                                host_int_n,
   output logic [2:0]                          fe_sensor_type,
   output logic [1:0]                          fe_hot_resolution
);

   // ----------------------------------------------------------------
   // pin synchronisers and conversion edge
   // ----------------------------------------------------------------
   logic [2:0]    tick_r;
   tcc_sample_t   raw_s1_r;
   tcc_sample_t   raw_s2_r;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tick_r   <= 3'h0;
         raw_s1_r <= '0;
         raw_s2_r <= '0;
      end else begin
         tick_r   <= {tick_r[1:0], fe_conv_tick};
         raw_s1_r <= {fe_hot_raw, fe_cold_raw};
         raw_s2_r <= raw_s1_r;
      end
   end

   // front end holds data stable around its tick edge, so the words are settled when the edge is seen
   wire tick_rise = tick_r[1] & ~tick_r[2];

   // ----------------------------------------------------------------
   // mode, burst control and sample acceptance
   // ----------------------------------------------------------------
   wire mode_normal = (operating_mode_select == TCC_MODE_NORMAL);           // [R2]
   wire mode_burst  = (operating_mode_select == TCC_MODE_BURST);

   logic                burst_active_r;
   logic [TCC_BCW-1:0]  burst_cnt_r;
   logic [2:0]          burst_n_r;

   wire [TCC_BCW-1:0] burst_target = 8'h01 << burst_n_r;                   // [R18]
   wire [TCC_BCW-1:0] burst_cnt_inc = burst_cnt_r + 8'h01;
   wire               take = tick_rise & (mode_normal | burst_active_r);   // [R26]
   wire               burst_last = burst_active_r & take & (burst_cnt_inc == burst_target);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         burst_active_r <= 1'b0;
         burst_cnt_r    <= TCC_BCNT_RST;
         burst_n_r      <= TCC_BURST_RST;
      end else if (burst_sample_count_write) begin
         burst_active_r <= mode_burst;                                     // [R18]
         burst_cnt_r    <= TCC_BCNT_RST;
         burst_n_r      <= burst_sample_count;
      end else if (!mode_burst || burst_last) begin
         burst_active_r <= 1'b0;                                           // [R18]
      end else if (burst_active_r && take) begin
         burst_cnt_r    <= burst_cnt_inc;
      end
   end

   // ----------------------------------------------------------------
   // resolution and filter
   // ----------------------------------------------------------------
   logic [TCC_TW-1:0] hres_mask;

   always_comb begin
      unique case (hot_resolution_select)                                  // [R1]
         2'd0: hres_mask = TCC_HRES_MASK0;
         2'd1: hres_mask = TCC_HRES_MASK1;
         2'd2: hres_mask = TCC_HRES_MASK2;
         2'd3: hres_mask = TCC_HRES_MASK3;
      endcase
   end

   wire signed [TCC_TW-1:0] hot_in  = raw_s2_r.hot & hres_mask;
   wire signed [TCC_TW-1:0] cold_in = raw_s2_r.cold & (cold_resolution_select ? TCC_CRES_MASK1 : 16'hffff); // [R24]

   logic signed [TCC_TW-1:0] hot_r;
   logic signed [TCC_TW-1:0] cold_r;
   logic signed [TCC_TW:0]   fdiff;
   logic signed [TCC_TW:0]   fstep;
   logic signed [TCC_TW-1:0] hot_nxt;

   // seeding on the first burst sample keeps an old value out of a fresh burst
   wire seed = (filter_strength_select == 3'd0) | (burst_active_r & (burst_cnt_r == TCC_BCNT_RST));

   always_comb begin
      fdiff   = {hot_in[TCC_TW-1], hot_in} - {hot_r[TCC_TW-1], hot_r};
      fstep   = fdiff >>> filter_strength_select;                          // [R23]
      hot_nxt = seed ? hot_in : TCC_TW'(hot_r + fstep[TCC_TW-1:0]);         // [R19]
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hot_r  <= TCC_TEMP_RST;
         cold_r <= TCC_TEMP_RST;
      end else if (take) begin
         hot_r  <= hot_nxt;                                                // [R13]
         cold_r <= cold_in;                                                // [R14]
      end
   end

   // ----------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------
   logic conv_done_r;
   logic burst_done_r;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         conv_done_r  <= 1'b0;
         burst_done_r <= 1'b0;
      end else begin
         // set beats the clearing read in the same cycle
         conv_done_r  <= take | (conv_done_r & ~hot_junction_read);        // [R16] [R17]
         burst_done_r <= burst_last | (burst_done_r & ~burst_sample_count_write); // [R20] [R21]
      end
   end

   // ----------------------------------------------------------------
   // alert channels
   // ----------------------------------------------------------------
   logic [TCC_NALERT-1:0][TCC_TW-1:0] limit_r;
   logic [TCC_NALERT-1:0][TCC_TW-1:0] hyst_r;
   tcc_alert_cfg_t [TCC_NALERT-1:0]   cfg_r;
   logic [TCC_NALERT-1:0]             alert_st_r;
   logic [TCC_NALERT-1:0]             trip;
   logic [TCC_NALERT-1:0]             pin_en;

   genvar gi;
   generate
      for (gi = 0; gi < TCC_NALERT; gi++) begin : g_alert
         wire sel_me = (alert_sel == 2'(gi));
         wire signed [TCC_TW-1:0] t_e = cfg_r[gi].junction_hot ? hot_r : cold_r; // [R7]
         wire signed [TCC_TW+1:0] t_x = {{2{t_e[TCC_TW-1]}}, t_e[TCC_TW-1:0]};
         wire signed [TCC_TW+1:0] lim = {{2{limit_r[gi][TCC_TW-1]}}, limit_r[gi]};
         wire signed [TCC_TW+1:0] hys = {2'b00, hyst_r[gi]};
         wire rel_up = t_x <= (lim - hys);                                 // [R5]
         wire rel_dn = t_x >= (lim + hys);
         wire release_c = cfg_r[gi].dir_falling ? rel_dn : rel_up;
         assign trip[gi]   = cfg_r[gi].dir_falling ? (t_x <= lim) : (t_x >= lim); // [R8]
         assign pin_en[gi] = cfg_r[gi].pin_en;

         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               limit_r[gi]    <= TCC_LIMIT_RST;
               hyst_r[gi]     <= TCC_HYST_RST;
               cfg_r[gi]      <= '0;
               alert_st_r[gi] <= 1'b0;
            end else begin
               if (alert_threshold_write && sel_me) begin
                  limit_r[gi] <= alert_value_in;                           // [R3]
               end
               if (alert_hysteresis_write && sel_me) begin
                  hyst_r[gi] <= alert_value_in;                            // [R5]
               end
               if (alert_configure && sel_me) begin
                  cfg_r[gi] <= alert_cfg_in;
               end
               // a live trip wins over the host clear
               if (trip[gi]) begin
                  alert_st_r[gi] <= 1'b1;                                  // [R25]
               end else if ((alert_clear && sel_me) || release_c) begin
                  alert_st_r[gi] <= 1'b0;                                  // [R10] [R25]
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   wire [TCC_NALERT-1:0] pin_act = alert_st_r & pin_en;                    // [R9]

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hot_junction_readout        <= TCC_TEMP_RST;
         cold_junction_readout       <= TCC_TEMP_RST;
         junction_difference_readout <= TCC_TEMP_RST;
         conversion_done_flag        <= 1'b0;
         burst_done_flag             <= 1'b0;
         status_readout              <= 8'h00;
         alert_threshold_readback    <= '0;
         alert_out_n                 <= 4'hf;
         host_int_n                  <= 1'b1;
         fe_sensor_type              <= 3'h0;
         fe_hot_resolution           <= 2'h0;
      end else begin
         hot_junction_readout        <= hot_r;
         cold_junction_readout       <= cold_r;
         junction_difference_readout <= TCC_TW'(hot_r - cold_r);           // [R15]
         conversion_done_flag        <= conv_done_r;
         burst_done_flag             <= burst_done_r;
         status_readout              <= {alert_st_r, 2'b00, burst_done_r, conv_done_r}; // [R12]
         alert_threshold_readback    <= limit_r;                           // [R11]
         alert_out_n                 <= ~pin_act;                          // [R6]
         host_int_n                  <= ~pin_act[0];                       // [R4]
         fe_sensor_type              <= sensor_type_select;                // [R22]
         fe_hot_resolution           <= hot_resolution_select;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   property p_conv_set;
      take |-> ##2 conversion_done_flag;
   endproperty
   a_conv_set: assert property (p_conv_set) else $error("conversion flag not set"); // [R16]

   property p_conv_clear;
      (hot_junction_read && !take) |=> !conv_done_r ##1 !conversion_done_flag;
   endproperty
   a_conv_clear: assert property (p_conv_clear) else $error("read did not clear flag"); // [R17]

   property p_burst_clear;
      (burst_sample_count_write && !burst_last) |-> ##2 !burst_done_flag;
   endproperty
   a_burst_clear: assert property (p_burst_clear) else $error("burst flag not cleared"); // [R21]

   property p_burst_end;
      burst_last |=> (burst_done_r && !burst_active_r) ##1 burst_done_flag;
   endproperty
   a_burst_end: assert property (p_burst_end) else $error("burst did not finish"); // [R18] [R20]

   property p_shutdown_idle;
      (!mode_normal && !burst_active_r) |=> $stable(hot_r) && $stable(cold_r);
   endproperty
   a_shutdown_idle: assert property (p_shutdown_idle) else $error("conversion in idle"); // [R26]

   property p_int_mirror;
      host_int_n == alert_out_n[0];
   endproperty
   a_int_mirror: assert property (p_int_mirror) else $error("interrupt differs from alert one"); // [R4]

   property p_pin_gate;
      ##1 ((~alert_out_n) & ~$past(pin_en)) == 4'h0;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("disabled pin active"); // [R9]

   property p_diff;
      junction_difference_readout == TCC_TW'(hot_junction_readout - cold_junction_readout);
   endproperty
   a_diff: assert property (p_diff) else $error("difference readout wrong"); // [R15]

   property p_trip_pin;
      (trip[0] && pin_en[0]) |-> ##2 !alert_out_n[0];
   endproperty
   a_trip_pin: assert property (p_trip_pin) else $error("alert one pin not low"); // [R6] [R25]

   property p_clear_one;
      (alert_clear && alert_sel == 2'd0 && !trip[0])
         |=> !alert_st_r[0] && (alert_st_r[1] || !$past(alert_st_r[1]) || $past(g_alert[1].release_c));
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("clear hit wrong channel"); // [R10]

   c_burst_done: cover property (burst_active_r ##[1:1000] burst_done_r);
   c_alert_trip: cover property ($rose(alert_st_r[0]));
   c_alert_clear: cover property (alert_clear && alert_sel == 2'd0 && alert_st_r[0] ##1 !alert_st_r[0]);
   c_conv_read: cover property (conv_done_r && hot_junction_read);

endmodule

`default_nettype wire

// file: tb/tcc_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// front end: one tick frame per request
// ------------------------------------------
module tcc_fe_model
   import tcc_pkg::*;
(
   input  wire logic              go,
   input  wire logic [TCC_TW-1:0] hot,
   input  wire logic [TCC_TW-1:0] cold,
   output logic                   busy = 1'b0,
   output logic                   tick = 1'b0,
   output logic [TCC_TW-1:0]      hot_raw = 16'h0000,
   output logic [TCC_TW-1:0]      cold_raw = 16'h0000
);
   always @(posedge go) begin
      busy = 1'b1;
      hot_raw = hot;
      cold_raw = cold;
      // kept off the clock edge so the sampling flop never races the pin
      #170 tick = 1'b1;
      #160 tick = 1'b0;
      // words flip once the hold time is over, so a late capture shows up
      hot_raw = ~hot;
      cold_raw = ~cold;
      busy = 1'b0;
   end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tcc_pkg::*;
   logic                  clk_sys = 1'b0, sys_rst = 1'b1, go = 1'b0;
   logic                  busy, fe_conv_tick;
   logic [TCC_TW-1:0]     fe_hot_raw, fe_cold_raw, hot_rd, cold_rd, diff_rd;
   logic [TCC_TW-1:0]     h_in = 16'h0000, c_in = 16'h0000, aval = 16'h0000;
   logic [1:0]            mode = 2'h0, hres = 2'h0, asel = 2'h0, fe_hres;
   logic [2:0]            stype = 3'h0, filt = 3'h0, bcnt = 3'h0, fe_type;
   logic                  cres = 1'b0, bwr = 1'b0, hrd = 1'b0, acfg = 1'b0;
   logic                  athr = 1'b0, ahys = 1'b0, aclr = 1'b0;
   tcc_alert_cfg_t        acin = 3'h0;
   logic                  conv_f, burst_f, int_n;
   logic [7:0]            stat;
   logic [3:0][TCC_TW-1:0] lim_rd;
   logic [3:0]            pin_n;
   int                    errors = 0, compares = 0;
   int                    mh, mc, md, f, bn, bsz, lim[4], hys[4];
   bit [2:0]              cfgm[4];
   bit [3:0]              st;
   bit                    mconv, mburst, bact, nod;

   tcc_conv_control u_tcc_conv_control (
      .clk_sys, .sys_rst, .fe_conv_tick, .fe_hot_raw, .fe_cold_raw, .operating_mode_select(mode),
      .hot_resolution_select(hres), .cold_resolution_select(cres), .sensor_type_select(stype),
      .filter_strength_select(filt), .burst_sample_count_write(bwr), .burst_sample_count(bcnt),
      .hot_junction_read(hrd), .alert_configure(acfg), .alert_threshold_write(athr),
      .alert_hysteresis_write(ahys), .alert_clear(aclr), .alert_sel(asel), .alert_cfg_in(acin),
      .alert_value_in(aval), .hot_junction_readout(hot_rd), .cold_junction_readout(cold_rd),
      .junction_difference_readout(diff_rd), .conversion_done_flag(conv_f), .burst_done_flag(burst_f),
      .status_readout(stat), .alert_threshold_readback(lim_rd), .alert_out_n(pin_n),
      .host_int_n(int_n), .fe_sensor_type(fe_type), .fe_hot_resolution(fe_hres));
   tcc_fe_model u_tcc_fe_model (.go, .hot(h_in), .cold(c_in), .busy, .tick(fe_conv_tick),
      .hot_raw(fe_hot_raw), .cold_raw(fe_cold_raw));

   always #20 clk_sys = ~clk_sys;

   // ------------------------------------------
   // checking and reference model
   // ------------------------------------------
   task automatic close_out;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic clk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   function automatic int rnd;
      return int'($urandom_range(4000)) - 2000;
   endfunction

   task automatic aeval(input bit clr, input int ch);
      int t;
      bit trip, rel;
      for (int i = 0; i < 4; i++) begin
         t = cfgm[i][2] ? mh : mc;
         trip = cfgm[i][1] ? t <= lim[i] : t >= lim[i];
         rel = cfgm[i][1] ? t >= lim[i] + hys[i] : t <= lim[i] - hys[i];
         if (trip)
            st[i] = 1'b1;
         else if (rel || (clr && ch == i))
            st[i] = 1'b0;
      end
   endtask

   task automatic cmp_all;
      chk(hot_rd, mh[15:0]);
      chk(cold_rd, mc[15:0]);
      if (!nod)
         chk(diff_rd, md[15:0]);
      chk(16'({burst_f, conv_f}), 16'({mburst, mconv}));
      chk(16'(stat), 16'({st, 2'h0, mburst, mconv}));
      chk(16'({int_n, pin_n}), 16'({~(st[0] & cfgm[0][0]),
         ~(st & {cfgm[3][0], cfgm[2][0], cfgm[1][0], cfgm[0][0]})}));
      for (int i = 0; i < 4; i++)
         chk(lim_rd[i], lim[i][15:0]);
   endtask

   task automatic conv(input int h, input int c);
      int b;
      @(posedge clk_sys);
      h_in <= h[15:0];
      c_in <= c[15:0];
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (40) if (busy === 1'b1) @(posedge clk_sys);
      clk(3);
      if (mode == 2'h0 || bact) begin
         b = hres < 2 ? 0 : hres - 1;
         h = h & ~((1 << b) - 1);
         c = cres ? c & ~3 : c;
         f = (bact && bn == 0) ? h : f + ((h - f) >>> filt);
         mh = f;
         mc = c;
         md = h - c;
         mconv = 1'b1;
         bn++;
         if (bact && bn == bsz) begin
            bact = 1'b0;
            mburst = 1'b1;
         end
      end
      aeval(0, 0);
   endtask

   task automatic host(input bit wr, input int n);
      @(posedge clk_sys);
      bcnt <= n[2:0];
      {bwr, hrd} <= wr ? 2'h2 : 2'h1;
      @(posedge clk_sys);
      {bwr, hrd} <= 2'h0;
      clk(3);
      if (wr) begin
         mburst = 1'b0;
         bact = (mode == 2'h2);
         bn = 0;
         bsz = 1 << n;
      end else
         mconv = 1'b0;
      cmp_all;
   endtask

   task automatic aw(input int op, input int ch, input int v);
      @(posedge clk_sys);
      asel <= ch[1:0];
      aval <= v[15:0];
      acin <= v[2:0];
      {aclr, ahys, athr, acfg} <= 4'h1 << op;
      @(posedge clk_sys);
      {aclr, ahys, athr, acfg} <= 4'h0;
      clk(3);
      case (op)
         0: cfgm[ch] = v[2:0];
         1: lim[ch] = v;
         2: hys[ch] = v;
         default: ;
      endcase
      aeval(op == 3, ch);
      cmp_all;
   endtask

   // ------------------------------------------
   // main sequence
   // ------------------------------------------
   initial begin
      void'($urandom(37663));
      clk(12);
      cmp_all;
      sys_rst <= 1'b0;
      aeval(0, 0);
      clk(4);
      cmp_all;
      for (int i = 0; i < 8; i++) begin
         stype <= i[2:0];
         clk(3);
         chk(16'(fe_type), 16'(i[2:0]));
      end
      for (int r = 0; r < 8; r++) begin
         hres <= r[1:0];
         cres <= r[2];
         conv(rnd(), rnd());
         chk(16'(fe_hres), 16'(r[1:0]));
         cmp_all;
      end
      // cold stays at 300 through the mode and burst steps, where only hot passes the filter
      conv(rnd(), 300);
      host(0, 0);
      mode <= 2'h1;
      conv(rnd(), 300);
      cmp_all;
      hres <= 2'h0;
      cres <= 1'b0;
      filt <= 3'h1;
      mode <= 2'h2;
      nod = 1'b1;
      host(1, 2);
      for (int k = 0; k < 5; k++) begin
         conv(rnd(), 300);
         cmp_all;
      end
      mode <= 2'h1;
      host(1, 0);
      mode <= 2'h2;
      host(1, 0);
      conv(rnd(), 300);
      cmp_all;
      host(1, 7);
      for (int k = 0; k < 128; k++) begin
         conv(rnd(), 300);
         if (k >= 126)
            cmp_all;
      end
      mode <= 2'h0;
      filt <= 3'h0;
      nod = 1'b0;
      conv(0, 300);
      for (int i = 0; i < 4; i++)
         aw(1, i, rnd());
      aw(1, 0, 400);
      aw(2, 0, 8);
      aw(0, 0, 5); // hot, rising, pin on
      aw(1, 1, 100);
      aw(0, 1, 3); // cold, falling, pin on
      aw(1, 2, -1000);
      aw(0, 2, 4); // pin off
      aw(1, 3, -1000);
      aw(0, 3, 7);
      conv(405, 50);
      cmp_all;
      conv(397, 50);
      cmp_all;
      aw(3, 0, 0);
      conv(401, 50);
      aw(3, 0, 0);
      conv(392, 50);
      cmp_all;
      close_out;
   end

   initial begin
      #400000;
      errors++;
      close_out;
   end
endmodule
`default_nettype wire
